// ==== common/bpr_pkg.sv ====
package bpr_pkg;
    localparam logic [5:0] ADDR_FIX   = 6'h25;
    localparam logic [6:0] IDX_PAGE   = 7'h00;
    localparam logic [6:0] IDX_BOOK   = 7'h7F;
    localparam logic [6:0] IDX_LAST   = 7'h7F;
    localparam logic [6:0] IDX_FIRST  = 7'h00;
    localparam logic [7:0] PAGE_ZERO  = 8'h00;
    localparam logic [7:0] PAGE_RST   = 8'h00;
    localparam logic [7:0] BOOK_RST   = 8'h00;
    localparam logic [3:0] BITS_BYTE  = 4'h8;
    localparam int         INC_BIT    = 7;
    localparam int         CLK_HZ     = 100_000_000;
    localparam int         SCL_HZ     = 100_000;
    localparam int         QTR_CYC    = CLK_HZ / (4 * SCL_HZ);
    localparam logic [6:0] SLV_RST    = {ADDR_FIX, 1'b0};
    localparam logic [3:0] WB_CMD     = 4'h0;
    localparam logic [3:0] WB_SLV     = 4'h4;
    localparam logic [3:0] WB_STAT    = 4'h8;
    localparam int         CMD_DAT_LSB = 0;
    localparam int         CMD_IDX_LSB = 8;
    localparam int         CMD_INC_BIT = 15;
    localparam int         CMD_RD_BIT  = 16;
    localparam int         STAT_BUSY   = 0;
    localparam int         STAT_NAK    = 1;
    localparam int         STAT_RD_LSB = 8;
    localparam logic [2:0] STP_AW     = 3'h0;
    localparam logic [2:0] STP_REG    = 3'h1;
    localparam logic [2:0] STP_DAT    = 3'h2;
    localparam logic [2:0] STP_AR     = 3'h3;
    localparam logic [2:0] STP_RD     = 3'h4;

    typedef enum logic [4:0] {
        D_IDLE = 5'b00001,
        D_RX   = 5'b00010,
        D_ACK  = 5'b00100,
        D_TX   = 5'b01000,
        D_MACK = 5'b10000
    } bpr_dst_t;

    typedef enum logic [2:0] {
        P_ADDR = 3'b001,
        P_REG  = 3'b010,
        P_DATA = 3'b100
    } bpr_ph_t;

    typedef enum logic [3:0] {
        H_IDLE  = 4'b0001,
        H_START = 4'b0010,
        H_BIT   = 4'b0100,
        H_STOP  = 4'b1000
    } bpr_hst_t;
endpackage : bpr_pkg

// ==== common/bpr_if.sv ====
`timescale 1ns/100ps
interface bpr_if;
    logic host_scl_oe;
    logic host_sda_oe;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: any enabled driver pulls low.
    assign scl = ~host_scl_oe;
    assign sda = ~(host_sda_oe | dev_sda_oe);

    modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
    modport dev  (output dev_sda_oe, input scl, input sda);
endinterface : bpr_if

// ==== logic/bpr_tick.sv ====
`timescale 1ns/100ps
module bpr_tick #(
    parameter int DIV = bpr_pkg::QTR_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic en_i,
    output logic      tick_o
);
    logic [15:0] cnt_ff;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || !en_i)
        begin
            cnt_ff <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (cnt_ff == 16'(DIV - 1))
        begin
            cnt_ff <= 16'h0000;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule : bpr_tick

// ==== logic/bpr_dev.sv ====
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
module bpr_dev (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    bpr_if.dev              bus,
    input  wire logic       adr_sel_i,
    input  wire logic [7:0] rd_data_i,
    output logic [7:0]      acc_book_o,
    output logic [7:0]      acc_page_o,
    output logic [6:0]      acc_idx_o,
    output logic            wr_stb_o,
    output logic [7:0]      wr_data_o
);
    logic [2:0]        scl_sy_ff;
    logic [2:0]        sda_sy_ff;
    logic [1:0]        sel_sy_ff;
    bpr_pkg::bpr_dst_t st_ff;
    bpr_pkg::bpr_ph_t  ph_ff;
    logic [3:0]        bcnt_ff;
    logic [7:0]        sh_ff;
    logic [7:0]        tx_ff;
    logic              rw_ff;
    logic              inc_ff;
    logic              sda_oe_ff;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_ev;
    logic              stop_ev;
    logic              byte_done;
    logic              addr_hit;
    logic              data_wr;
    logic              tx_adv;
    logic [7:0]        rd_val;
    logic [6:0]        nxt_idx;

    // The second stage of each synchroniser feeds logic; on clock and data the third is its delayed copy for edge detection.
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            scl_sy_ff <= 3'h7;
            sda_sy_ff <= 3'h7;
            sel_sy_ff <= 2'h0;
        end
        else
        begin
            scl_sy_ff <= {scl_sy_ff[1:0], bus.scl};
            sda_sy_ff <= {sda_sy_ff[1:0], bus.sda};
            sel_sy_ff <= {sel_sy_ff[0], adr_sel_i};
        end
    end

    assign scl_rise  = scl_sy_ff[1] & ~scl_sy_ff[2];
    assign scl_fall  = ~scl_sy_ff[1] & scl_sy_ff[2];
    assign start_ev  = scl_sy_ff[1] & scl_sy_ff[2] & ~sda_sy_ff[1] & sda_sy_ff[2];
    assign stop_ev   = scl_sy_ff[1] & scl_sy_ff[2] & sda_sy_ff[1] & ~sda_sy_ff[2];
    assign byte_done = (st_ff == bpr_pkg::D_RX) && scl_fall && (bcnt_ff == bpr_pkg::BITS_BYTE);
    assign addr_hit  = (sh_ff[7:1] == {bpr_pkg::ADDR_FIX, sel_sy_ff[1]});
    assign data_wr   = byte_done && (ph_ff == bpr_pkg::P_DATA);
    assign tx_adv    = (st_ff == bpr_pkg::D_MACK) && scl_rise;

    // Wrap stays inside the page: the page register is never touched by the index.
    assign nxt_idx = (acc_idx_o == bpr_pkg::IDX_LAST) ? bpr_pkg::IDX_FIRST : acc_idx_o + 7'h01;

    always_comb
    begin
        if (acc_idx_o == bpr_pkg::IDX_PAGE)
        begin
            rd_val = acc_page_o;
        end
        else if ((acc_idx_o == bpr_pkg::IDX_BOOK) && (acc_page_o == bpr_pkg::PAGE_ZERO))
        begin
            rd_val = acc_book_o;
        end
        else
        begin
            rd_val = rd_data_i;
        end
    end

    // The device never drives the clock line and only releases or pulls data.
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            st_ff     <= bpr_pkg::D_IDLE;
            ph_ff     <= bpr_pkg::P_ADDR;
            bcnt_ff   <= 4'h0;
            sh_ff     <= 8'h00;
            tx_ff     <= 8'h00;
            rw_ff     <= 1'b0;
            sda_oe_ff <= 1'b0;
        end
        else if (stop_ev)
        begin
            st_ff     <= bpr_pkg::D_IDLE;
            sda_oe_ff <= 1'b0;
        end
        else if (start_ev)
        begin
            // Repeated start lands here too; the index is kept for the read.
            st_ff     <= bpr_pkg::D_RX;
            ph_ff     <= bpr_pkg::P_ADDR;
            bcnt_ff   <= 4'h0;
            sda_oe_ff <= 1'b0;
        end
        else
        begin
            case (st_ff)
                bpr_pkg::D_IDLE:
                begin
                    sda_oe_ff <= 1'b0;
                end
                bpr_pkg::D_RX:
                begin
                    if (scl_rise && (bcnt_ff != bpr_pkg::BITS_BYTE))
                    begin
                        sh_ff   <= {sh_ff[6:0], sda_sy_ff[1]};
                        bcnt_ff <= bcnt_ff + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        bcnt_ff <= 4'h0;
                        if ((ph_ff == bpr_pkg::P_ADDR) && !addr_hit)
                        begin
                            st_ff <= bpr_pkg::D_IDLE;
                        end
                        else
                        begin
                            st_ff     <= bpr_pkg::D_ACK;
                            sda_oe_ff <= 1'b1;
                            if (ph_ff == bpr_pkg::P_ADDR)
                            begin
                                rw_ff <= sh_ff[0];
                            end
                        end
                    end
                end
                bpr_pkg::D_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rw_ff)
                        begin
                            st_ff     <= bpr_pkg::D_TX;
                            sda_oe_ff <= ~rd_val[7];
                            tx_ff     <= {rd_val[6:0], 1'b0};
                            bcnt_ff   <= 4'h1;
                        end
                        else
                        begin
                            st_ff     <= bpr_pkg::D_RX;
                            sda_oe_ff <= 1'b0;
                            ph_ff     <= (ph_ff == bpr_pkg::P_ADDR) ? bpr_pkg::P_REG : bpr_pkg::P_DATA;
                        end
                    end
                end
                bpr_pkg::D_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bcnt_ff == bpr_pkg::BITS_BYTE)
                        begin
                            st_ff     <= bpr_pkg::D_MACK;
                            sda_oe_ff <= 1'b0;
                        end
                        else
                        begin
                            sda_oe_ff <= ~tx_ff[7];
                            tx_ff     <= {tx_ff[6:0], 1'b0};
                            bcnt_ff   <= bcnt_ff + 4'h1;
                        end
                    end
                end
                bpr_pkg::D_MACK:
                begin
                    if (scl_rise)
                    begin
                        // A not-acknowledge ends the read; the host then sends stop.
                        st_ff <= sda_sy_ff[1] ? bpr_pkg::D_IDLE : bpr_pkg::D_ACK;
                    end
                end
                default:
                begin
                    st_ff     <= bpr_pkg::D_IDLE;
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // Index and increment flag. Without the flag a burst keeps rewriting one register.
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            acc_idx_o <= bpr_pkg::IDX_FIRST;
            inc_ff    <= 1'b0;
        end
        else if (byte_done && (ph_ff == bpr_pkg::P_REG))
        begin
            inc_ff    <= sh_ff[bpr_pkg::INC_BIT];
            acc_idx_o <= sh_ff[6:0];
        end
        else if ((data_wr || tx_adv) && inc_ff)
        begin
            acc_idx_o <= nxt_idx;
        end
    end

    // Page and book selectors live inside the port so they work in every book.
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            acc_page_o <= bpr_pkg::PAGE_RST;
            acc_book_o <= bpr_pkg::BOOK_RST;
        end
        else if (data_wr && (acc_idx_o == bpr_pkg::IDX_PAGE))
        begin
            acc_page_o <= sh_ff;
        end
        else if (data_wr && (acc_idx_o == bpr_pkg::IDX_BOOK) && (acc_page_o == bpr_pkg::PAGE_ZERO))
        begin
            acc_book_o <= sh_ff;
        end
    end

    // Writes to all other registers leave as a one-cycle strobe for the register space.
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            wr_stb_o  <= 1'b0;
            wr_data_o <= 8'h00;
        end
        else
        begin
            wr_stb_o <= data_wr && (acc_idx_o != bpr_pkg::IDX_PAGE)
                        && !((acc_idx_o == bpr_pkg::IDX_BOOK) && (acc_page_o == bpr_pkg::PAGE_ZERO));
            if (data_wr)
            begin
                wr_data_o <= sh_ff;
            end
        end
    end

    assign bus.dev_sda_oe = sda_oe_ff;
endmodule : bpr_dev

// ==== logic/bpr_host.sv ====
`timescale 1ns/100ps
module bpr_host #(
    parameter int QTR = bpr_pkg::QTR_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    bpr_if.host              bus
);
    bpr_pkg::bpr_hst_t st_ff;
    logic [1:0]        sda_sy_ff;
    logic [1:0]        qph_ff;
    logic [2:0]        stp_ff;
    logic [3:0]        bcnt_ff;
    logic [8:0]        tx_ff;
    logic [8:0]        rx_ff;
    logic [6:0]        slv_ff;
    logic [7:0]        dat_ff;
    logic [6:0]        idx_ff;
    logic              inc_ff;
    logic              rd_ff;
    logic              nak_ff;
    logic [7:0]        rdat_ff;
    logic              scl_oe_ff;
    logic              sda_oe_ff;
    logic              tick;
    logic              wb_req;
    logic              go;
    logic              busy;

    assign busy   = (st_ff != bpr_pkg::H_IDLE);
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // A command written while busy is acknowledged but dropped.
    assign go     = wb_req && wb_we_i && (wb_adr_i == bpr_pkg::WB_CMD) && (wb_sel_i == 4'hF) && !busy;

    bpr_tick #(.DIV(QTR)) u_tick (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .en_i    (busy),
        .tick_o  (tick)
    );

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            sda_sy_ff <= 2'h3;
        end
        else
        begin
            sda_sy_ff <= {sda_sy_ff[0], bus.sda};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            slv_ff   <= bpr_pkg::SLV_RST;
            dat_ff   <= 8'h00;
            idx_ff   <= 7'h00;
            inc_ff   <= 1'b0;
            rd_ff    <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    bpr_pkg::WB_SLV:  wb_dat_o <= {25'h0, slv_ff};
                    bpr_pkg::WB_STAT: wb_dat_o <= {16'h0, rdat_ff, 6'h0, nak_ff, busy};
                    default:          wb_dat_o <= 32'h0000_0000;
                endcase
            end
            if (wb_req && wb_we_i && (wb_adr_i == bpr_pkg::WB_SLV) && wb_sel_i[0])
            begin
                slv_ff <= wb_dat_i[6:0];
            end
            if (go)
            begin
                dat_ff <= wb_dat_i[bpr_pkg::CMD_DAT_LSB +: 8];
                idx_ff <= wb_dat_i[bpr_pkg::CMD_IDX_LSB +: 7];
                inc_ff <= wb_dat_i[bpr_pkg::CMD_INC_BIT];
                rd_ff  <= wb_dat_i[bpr_pkg::CMD_RD_BIT];
            end
        end
    end

    // Each bit takes four quarter ticks: set data, raise clock, sample, lower clock.
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            st_ff     <= bpr_pkg::H_IDLE;
            qph_ff    <= 2'h0;
            stp_ff    <= bpr_pkg::STP_AW;
            bcnt_ff   <= 4'h0;
            tx_ff     <= 9'h000;
            rx_ff     <= 9'h000;
            nak_ff    <= 1'b0;
            rdat_ff   <= 8'h00;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end
        else if (st_ff == bpr_pkg::H_IDLE)
        begin
            if (go)
            begin
                st_ff  <= bpr_pkg::H_START;
                qph_ff <= 2'h0;
                stp_ff <= bpr_pkg::STP_AW;
                nak_ff <= 1'b0;
            end
        end
        else if (tick)
        begin
            qph_ff <= qph_ff + 2'h1;
            case (st_ff)
                bpr_pkg::H_START:
                begin
                    case (qph_ff)
                        2'h0:    sda_oe_ff <= 1'b0;
                        2'h1:    scl_oe_ff <= 1'b0;
                        2'h2:    sda_oe_ff <= 1'b1;
                        default:
                        begin
                            scl_oe_ff <= 1'b1;
                            st_ff     <= bpr_pkg::H_BIT;
                            bcnt_ff   <= 4'h0;
                            tx_ff     <= {slv_ff, stp_ff == bpr_pkg::STP_AR, 1'b1};
                        end
                    endcase
                end
                bpr_pkg::H_BIT:
                begin
                    case (qph_ff)
                        2'h0:    sda_oe_ff <= ~tx_ff[8];
                        2'h1:    scl_oe_ff <= 1'b0;
                        2'h2:    rx_ff     <= {rx_ff[7:0], sda_sy_ff[1]};
                        default:
                        begin
                            scl_oe_ff <= 1'b1;
                            tx_ff     <= {tx_ff[7:0], 1'b0};
                            bcnt_ff   <= bcnt_ff + 4'h1;
                            if (bcnt_ff == bpr_pkg::BITS_BYTE)
                            begin
                                bcnt_ff <= 4'h0;
                                if ((stp_ff != bpr_pkg::STP_RD) && rx_ff[0])
                                begin
                                    nak_ff <= 1'b1;
                                    st_ff  <= bpr_pkg::H_STOP;
                                end
                                else
                                begin
                                    case (stp_ff)
                                        bpr_pkg::STP_AW:
                                        begin
                                            stp_ff <= bpr_pkg::STP_REG;
                                            tx_ff  <= {inc_ff, idx_ff, 1'b1};
                                        end
                                        bpr_pkg::STP_REG:
                                        begin
                                            if (rd_ff)
                                            begin
                                                stp_ff <= bpr_pkg::STP_AR;
                                                st_ff  <= bpr_pkg::H_START;
                                            end
                                            else
                                            begin
                                                stp_ff <= bpr_pkg::STP_DAT;
                                                tx_ff  <= {dat_ff, 1'b1};
                                            end
                                        end
                                        bpr_pkg::STP_AR:
                                        begin
                                            stp_ff <= bpr_pkg::STP_RD;
                                            tx_ff  <= 9'h1FF;
                                        end
                                        bpr_pkg::STP_RD:
                                        begin
                                            rdat_ff <= rx_ff[8:1];
                                            st_ff   <= bpr_pkg::H_STOP;
                                        end
                                        default: st_ff <= bpr_pkg::H_STOP;
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                bpr_pkg::H_STOP:
                begin
                    case (qph_ff)
                        2'h0:    sda_oe_ff <= 1'b1;
                        2'h1:    scl_oe_ff <= 1'b0;
                        2'h2:    sda_oe_ff <= 1'b0;
                        default: st_ff     <= bpr_pkg::H_IDLE;
                    endcase
                end
                default: st_ff <= bpr_pkg::H_IDLE;
            endcase
        end
    end

    assign bus.host_scl_oe = scl_oe_ff;
    assign bus.host_sda_oe = sda_oe_ff;
endmodule : bpr_host

// ==== dv/bpr_monitor.sv ====
`timescale 1ns/100ps
module bpr_monitor #(
    parameter int QTR = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [15:0] hi_cnt_ff;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Counts how long the clock line has been high, to bound the high phase from below.
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            hi_cnt_ff <= 16'h0;
        else
            hi_cnt_ff <= scl ? hi_cnt_ff + 16'h1 : 16'h0;
    end

    a_dev_no_frame: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device moved data line while clock high");
    a_dev_after_fall: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
        else $error("device changed data line too close to clock rise");
    a_ack_hold: assert property ($rose(dev_sda_oe) |=> dev_sda_oe [*8])
        else $error("device pulled data line for too short a time");
    a_dev_release: assert property ($rose(dev_sda_oe) |-> ##[1:400] $fell(dev_sda_oe))
        else $error("device did not release data line");
    a_reset_idle: assert property ($rose(rst_b_i) |-> scl && sda)
        else $error("bus not idle after reset");
    a_scl_high_len: assert property ($fell(scl) |-> hi_cnt_ff >= QTR)
        else $error("clock high phase too short");
    a_host_sda_edge: assert property ($fell(scl) |-> $stable(host_sda_oe))
        else $error("host moved data line on clock fall");
    a_scl_low_min: assert property ($rose(host_scl_oe) |=> host_scl_oe [*4])
        else $error("clock low phase too short");
endmodule : bpr_monitor

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    typedef struct {logic sel; logic [6:0] slv; logic rd; logic inc; logic [6:0] idx; logic [7:0] dat;
                    logic [7:0] pg; logic [7:0] bk; logic [6:0] ei; logic nk; logic wr;} bpr_row_t;
    logic        clk_i   = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic        adr_sel = 1'b0;
    logic [3:0]  adr     = 4'h0;
    logic [3:0]  sel     = 4'h0;
    logic [31:0] wdat    = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        wr_stb;
    logic [7:0]  book;
    logic [7:0]  page;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic [7:0]  wr_dat;
    logic [6:0]  idx;
    logic [6:0]  idx_q;
    logic [6:0]  wr_adr;
    int          wr_cnt    = 0;
    int          cnt0;
    int          bad_count = 0;
    int          cmp_count = 0;
    bpr_row_t    rows[12]  = '{
        '{1'h0, 7'h4A, 1'h0, 1'h0, 7'h00, 8'h21, 8'h21, 8'h00, 7'h00, 1'h0, 1'h0},
        '{1'h0, 7'h4A, 1'h0, 1'h1, 7'h10, 8'h33, 8'h21, 8'h00, 7'h11, 1'h0, 1'h1},
        '{1'h0, 7'h4A, 1'h0, 1'h1, 7'h7F, 8'h44, 8'h21, 8'h00, 7'h00, 1'h0, 1'h1},
        '{1'h0, 7'h4A, 1'h1, 1'h1, 7'h05, 8'h00, 8'h21, 8'h00, 7'h06, 1'h0, 1'h0},
        '{1'h0, 7'h4A, 1'h1, 1'h0, 7'h09, 8'h00, 8'h21, 8'h00, 7'h09, 1'h0, 1'h0},
        '{1'h0, 7'h4A, 1'h1, 1'h1, 7'h00, 8'h00, 8'h21, 8'h00, 7'h01, 1'h0, 1'h0},
        '{1'h0, 7'h4A, 1'h0, 1'h0, 7'h00, 8'h00, 8'h00, 8'h00, 7'h00, 1'h0, 1'h0},
        '{1'h0, 7'h4A, 1'h0, 1'h0, 7'h7F, 8'h8C, 8'h00, 8'h8C, 7'h7F, 1'h0, 1'h0},
        '{1'h0, 7'h4B, 1'h0, 1'h1, 7'h20, 8'h55, 8'h00, 8'h8C, 7'h7F, 1'h1, 1'h0},
        '{1'h0, 7'h4A, 1'h1, 1'h1, 7'h7F, 8'h00, 8'h00, 8'h8C, 7'h00, 1'h0, 1'h0},
        '{1'h1, 7'h4B, 1'h0, 1'h1, 7'h20, 8'h55, 8'h00, 8'h8C, 7'h21, 1'h0, 1'h1},
        '{1'h1, 7'h4B, 1'h0, 1'h0, 7'h00, 8'h5A, 8'h5A, 8'h8C, 7'h00, 1'h0, 1'h0}};

    bpr_if bus_if ();
    bpr_host #(.QTR(8)) bpr_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .bus(bus_if));
    bpr_dev bpr_dev_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(bus_if), .adr_sel_i(adr_sel), .rd_data_i(rd_data),
        .acc_book_o(book), .acc_page_o(page), .acc_idx_o(idx), .wr_stb_o(wr_stb), .wr_data_o(wr_data));
    bpr_monitor #(.QTR(8)) bpr_monitor_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .host_scl_oe(bus_if.host_scl_oe),
        .host_sda_oe(bus_if.host_sda_oe), .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

    // Read data mixes the low nibbles of page and index, so a byte from a place differing in either nibble cannot pass.
    assign rd_data = {idx[3:0], page[3:0]} ^ 8'hA5;
    always #5 clk_i = ~clk_i;

    // The write targets the index of the cycle before the strobe.
    always @(posedge clk_i)
    begin
        idx_q <= idx;
        if (wr_stb === 1'b1)
        begin
            wr_cnt <= wr_cnt + 1;
            wr_adr <= idx_q;
            wr_dat <= wr_data;
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask : wb

    task automatic run(input bpr_row_t r);
        logic [7:0] exp_rd;
        adr_sel <= r.sel;
        cnt0 = wr_cnt;
        // Selector registers answer from the port itself, everything else from the register space.
        exp_rd = {r.idx[3:0], r.pg[3:0]} ^ 8'hA5;
        if (r.idx == 7'h00)
            exp_rd = r.pg;
        else if ((r.idx == 7'h7F) && (r.pg == 8'h00))
            exp_rd = r.bk;
        wb(1'b1, bpr_pkg::WB_SLV, {25'h0, r.slv});
        wb(1'b1, bpr_pkg::WB_CMD, {15'h0, r.rd, r.inc, r.idx, r.dat});
        do wb(1'b0, bpr_pkg::WB_STAT, 32'h0); while (q[bpr_pkg::STAT_BUSY] !== 1'b0);
        `CHK("nak", r.nk, q[bpr_pkg::STAT_NAK])
        if (r.rd)
            `CHK("read byte", exp_rd, q[15:8])
        `CHK("page", r.pg, page)
        `CHK("book", r.bk, book)
        `CHK("index", r.ei, idx)
        `CHK("writes", cnt0 + int'(r.wr), wr_cnt)
        if (r.wr)
        begin
            `CHK("write index", r.idx, wr_adr)
            `CHK("write data", r.dat, wr_dat)
        end
    endtask : run

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        `CHK("page after reset", 8'h00, page)
        `CHK("book after reset", 8'h00, book)
        wb(1'b0, bpr_pkg::WB_SLV, 32'h0);
        `CHK("slave after reset", 32'h0000004A, q)
        wb(1'b0, 4'hC, 32'h0);
        `CHK("unmapped", 32'h00000000, q)
        tally_and_finish();
    end

    // Twelve transfers at a 32-clock bit take about a third of this span.
    initial
    begin
        repeat (40000) @(posedge clk_i);
        bad_count++;
        tally_and_finish();
    end
endmodule : testbench
